/* hdl/bcie_defs.svh */
// constants for the bit and carry instruction executor
// assumes a 10-bit instruction word from the fetch stage
`ifndef BCIE_DEFS_SVH
`define BCIE_DEFS_SVH
`define BCIE_OP_ROT_RIGHT 10'h01d
`define BCIE_OP_CARRY_CLR 10'h006
`define BCIE_OP_PORTC_CLR 10'h28c
`define BCIE_OP_BITCLR_BASE 10'h04c
`define BCIE_OP_BITCLR_MASK 10'h3fc
`define BCIE_NIBBLE_ZERO 4'h0
`define BCIE_CARRY_RESET 1'b0
`define BCIE_PORTC_RESET 1'b0
`define BCIE_PORTC_SET 1'b1
`endif

/* hdl/bcie_pkg.sv */
// types for the bit and carry instruction executor
// assumes the defines header is included by users
package bcie_pkg;
	typedef struct packed {
		logic [3:0] acc;
		logic carry_flag;
	} bcie_acc_t;

	typedef struct packed {
		logic we;
		logic [3:0] data;
	} bcie_mem_wr_t;

	typedef enum logic [3:0] {
		BCIE_NONE = 4'h0,
		BCIE_ROT = 4'h1,
		BCIE_BCLR = 4'h2,
		BCIE_CCLR = 4'h4,
		BCIE_PCLR = 4'h8
	} bcie_op_t;
endpackage : bcie_pkg

/* hdl/bcie_exec.sv */
// executes rotate-right, bit clear, carry clear and port c clear
// assumes memory read data for the nibble at the data pointer is valid in the cycle of the instruction
// assumes port_c_set comes from the port c set logic elsewhere in the core, one cycle per request
// Functional notes
// - rotate right: acc shifts toward bit 0, old carry to bit 3, carry gets bit 0.
// - bit clear writes zero to one memory bit, other bits kept.
// - cleared bit index comes from the two-bit immediate field, 0 to 3.
// - carry clear forces carry to zero in one single-cycle word, no skip.
`timescale 1ns/1ps
`include "bcie_defs.svh"
module bcie_exec (
	input wire logic clk, // core clock
	input wire logic rst, // sync reset, high
	input wire logic instr_valid, // instruction present this cycle
	input wire logic [9:0] instr, // instruction word
	input wire bcie_pkg::bcie_acc_t acc_in, // accumulator and carry from datapath
	input wire logic [3:0] mem_rdata, // nibble at data_pointer
	input wire logic port_c_set, // port c latch set from elsewhere in the core
	output bcie_pkg::bcie_acc_t acc_out, // registered accumulator and carry result
	output logic acc_we, // acc_out valid, one cycle
	output bcie_pkg::bcie_mem_wr_t mem_wr, // registered memory write
	output logic port_c_latch, // port c output latch
	output logic skip // skip request, never set here
);
	////////////////////////////////////////////////////////////////
	// one decode feeds the result muxes, the write strobes and the checks below
	function automatic bcie_pkg::bcie_op_t op_decode(input logic valid, input logic [9:0] word);
		bcie_pkg::bcie_op_t kind;
		kind = bcie_pkg::BCIE_NONE;
		if (!valid) begin
			kind = bcie_pkg::BCIE_NONE;
		end else if (word == `BCIE_OP_ROT_RIGHT) begin
			kind = bcie_pkg::BCIE_ROT;
		end else if (word == `BCIE_OP_CARRY_CLR) begin
			kind = bcie_pkg::BCIE_CCLR;
		end else if (word == `BCIE_OP_PORTC_CLR) begin
			kind = bcie_pkg::BCIE_PCLR;
		end else if ((word & `BCIE_OP_BITCLR_MASK) == `BCIE_OP_BITCLR_BASE) begin
			kind = bcie_pkg::BCIE_BCLR;
		end
		return kind;
	endfunction : op_decode

	// one-hot select of a nibble bit
	function automatic logic [3:0] bit_select(input logic [1:0] idx);
		logic [3:0] onehot;
		onehot = `BCIE_NIBBLE_ZERO;
		onehot[idx] = 1'b1;
		return onehot;
	endfunction : bit_select

	bcie_pkg::bcie_op_t op_kind;
	assign op_kind = op_decode(instr_valid, instr);
	// unknown words decode to none and leave acc_we, mem_wr and skip quiet; acc_out still loads acc_in
	wire rotate_acc_right_op = (op_kind == bcie_pkg::BCIE_ROT);
	wire carry_clear_op = (op_kind == bcie_pkg::BCIE_CCLR);
	wire port_c_clear_op = (op_kind == bcie_pkg::BCIE_PCLR);
	wire mem_bit_clear_op = (op_kind == bcie_pkg::BCIE_BCLR);
	wire [1:0] bit_idx = instr[1:0];
	wire [3:0] clr_mask = bit_select(bit_idx);

	// only the picked bit is forced low; the other three pass as read
	wire [3:0] mem_next;
	for (genvar b = 0; b < 4; b++) begin : g_nibble_bit
		assign mem_next[b] = mem_rdata[b] & ~clr_mask[b];
	end

	wire [3:0] rot_acc = {acc_in.carry_flag, acc_in.acc[3:1]};
	wire rot_carry = acc_in.acc[0];

	bcie_pkg::bcie_acc_t acc_next;
	always_comb begin
		acc_next = acc_in;
		case (op_kind)
			bcie_pkg::BCIE_ROT: begin
				acc_next.acc = rot_acc;
				acc_next.carry_flag = rot_carry;
			end
			bcie_pkg::BCIE_CCLR: begin
				acc_next.carry_flag = `BCIE_CARRY_RESET;
			end
			default: begin
				acc_next = acc_in;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next values kept apart from the flops so each flop block stays a plain load
	wire acc_we_next = rotate_acc_right_op || carry_clear_op;
	bcie_pkg::bcie_mem_wr_t mem_wr_next;
	// data stays zero between writes so a stray strobe cannot carry old data
	assign mem_wr_next = {mem_bit_clear_op, mem_bit_clear_op ? mem_next : `BCIE_NIBBLE_ZERO};
	// set and clear come from different instruction words and should never meet;
	// if they do, the set wins and the clear is lost
	wire port_c_next = port_c_set ? `BCIE_PORTC_SET : (port_c_clear_op ? `BCIE_PORTC_RESET : port_c_latch);

	// accumulator and carry; the datapath takes them only while acc_we is high
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_out <= '0;
		end else begin
			acc_out <= acc_next;
		end
	end

	// one-cycle strobe for the write-back
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_we <= 1'b0;
		end else begin
			acc_we <= acc_we_next;
		end
	end

	// strobe and data in one flop block so they cannot skew
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_wr <= '0;
		end else begin
			mem_wr <= mem_wr_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_c_latch <= `BCIE_PORTC_RESET;
		end else begin
			port_c_latch <= port_c_next;
		end
	end

	// single-word ops never skip
	assign skip = 1'b0;

	////////////////////////////////////////////////////////////////
	// every check but a_mem_data_idle looks one edge after the instruction or reset, where the flops answer
	a_rot_result: assert property (@(posedge clk) disable iff (rst)
		rotate_acc_right_op |=> acc_we && acc_out.acc == {$past(acc_in.carry_flag), $past(acc_in.acc[3:1])}
			&& acc_out.carry_flag == $past(acc_in.acc[0]))
		else $error("rotate result wrong");

	a_acc_quiet: assert property (@(posedge clk) disable iff (rst)
		!(rotate_acc_right_op || carry_clear_op) |=> !acc_we)
		else $error("stray accumulator write");

	a_acc_ops_no_mem: assert property (@(posedge clk) disable iff (rst)
		rotate_acc_right_op || carry_clear_op |=> !mem_wr.we)
		else $error("accumulator op wrote memory");

	a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
		!instr_valid && !port_c_set |=> !acc_we && !mem_wr.we && port_c_latch == $past(port_c_latch))
		else $error("idle cycle not quiet");

	// memory write strobe and data, then the carry clear result
	a_bit_clear: assert property (@(posedge clk) disable iff (rst)
		mem_bit_clear_op |=> mem_wr.we && mem_wr.data[$past(bit_idx)] == 1'b0)
		else $error("bit not cleared");

	a_bit_keep: assert property (@(posedge clk) disable iff (rst)
		mem_bit_clear_op |=> (mem_wr.data | (4'h1 << $past(bit_idx))) == ($past(mem_rdata) | (4'h1 << $past(bit_idx))))
		else $error("other bits changed");

	a_no_stray_write: assert property (@(posedge clk) disable iff (rst)
		!mem_bit_clear_op |=> !mem_wr.we)
		else $error("stray memory write");

	a_mem_data_idle: assert property (@(posedge clk) disable iff (rst)
		!mem_wr.we |-> mem_wr.data == `BCIE_NIBBLE_ZERO)
		else $error("memory data not idle");

	a_bitclr_no_acc: assert property (@(posedge clk) disable iff (rst)
		mem_bit_clear_op |=> !acc_we)
		else $error("bit clear wrote accumulator");

	a_carry_clear: assert property (@(posedge clk) disable iff (rst)
		carry_clear_op |=> acc_we && !acc_out.carry_flag && acc_out.acc == $past(acc_in.acc) && !skip)
		else $error("carry clear wrong");

	// port c latch: cleared by the instruction, set from outside
	a_portc_clear: assert property (@(posedge clk) disable iff (rst)
		port_c_clear_op && !port_c_set |=> !port_c_latch)
		else $error("port c not cleared");

	a_portc_set: assert property (@(posedge clk) disable iff (rst)
		port_c_set |=> port_c_latch)
		else $error("port c not set");

	a_portc_hold: assert property (@(posedge clk) disable iff (rst)
		!port_c_set && !port_c_clear_op |=> port_c_latch == $past(port_c_latch))
		else $error("port c changed");

	a_portc_no_acc: assert property (@(posedge clk) disable iff (rst)
		port_c_clear_op |=> !acc_we && !mem_wr.we)
		else $error("port c clear touched datapath");

	// no disable here: this one watches the reset itself
	a_reset_quiet: assert property (@(posedge clk)
		rst |=> !acc_we && !mem_wr.we && !port_c_latch && acc_out == '0)
		else $error("outputs not cleared by reset");

	////////////////////////////////////////////////////////////////
	// per-bit view of the bit clear: the picked bit reads zero, the rest follow memory
	for (genvar k = 0; k < 4; k++) begin : g_bit_check
		a_bit_picked: assert property (@(posedge clk) disable iff (rst)
			mem_bit_clear_op && bit_idx == 2'(k) |=> !mem_wr.data[k])
			else $error("picked bit not cleared");
		a_bit_other: assert property (@(posedge clk) disable iff (rst)
			mem_bit_clear_op && bit_idx != 2'(k) |=> mem_wr.data[k] == $past(mem_rdata[k]))
			else $error("unpicked bit changed");
	end

	////////////////////////////////////////////////////////////////
	c_rotate: cover property (@(posedge clk) rotate_acc_right_op && acc_in.carry_flag && !acc_in.acc[0]);
	c_bit3: cover property (@(posedge clk) mem_bit_clear_op && bit_idx == 2'h3);
	c_carry: cover property (@(posedge clk) carry_clear_op && acc_in.carry_flag);
	c_portc: cover property (@(posedge clk) port_c_clear_op && port_c_latch);
	c_set_then_clear: cover property (@(posedge clk) port_c_set ##2 port_c_clear_op);
endmodule : bcie_exec

/* dv/test_bit_and_carry_instr_exec.sv */
// bench for the bit and carry instruction executor
// drives every port itself; no partner model
`timescale 1ns/1ps
`include "bcie_defs.svh"
module test_bit_and_carry_instr_exec;
	logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, port_c_set = 1'b0, acc_we, port_c_latch, skip;
	logic [9:0] instr = 10'h000;
	logic [3:0] mem_rdata = 4'h0;
	bcie_pkg::bcie_acc_t acc_in = 5'h00, acc_out;
	bcie_pkg::bcie_mem_wr_t mem_wr;
	int fails = 0, checks_done = 0;
	bcie_exec bcie_exec_inst (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .acc_in(acc_in),
		.mem_rdata(mem_rdata), .port_c_set(port_c_set), .acc_out(acc_out), .acc_we(acc_we), .mem_wr(mem_wr),
		.port_c_latch(port_c_latch), .skip(skip));
	initial begin
		forever #4 clk = ~clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one instruction, outputs sampled after the answering edge
	task run(input logic [9:0] op, input logic [4:0] a, input logic [3:0] m);
		@(posedge clk);
		instr <= op;
		instr_valid <= 1'b1;
		acc_in <= a;
		mem_rdata <= m;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask : run
	////////////////////////////////////////////////////////////
	task rotate_test;
		run(`BCIE_OP_ROT_RIGHT, {4'h6, 1'b1}, 4'h0);
		chk({acc_we, acc_out}, {1'b1, 4'hb, 1'b0});
		run(`BCIE_OP_ROT_RIGHT, {4'h9, 1'b0}, 4'h0);
		chk({acc_we, acc_out}, {1'b1, 4'h4, 1'b1});
	endtask : rotate_test
	task bitclr_test;
		run(`BCIE_OP_BITCLR_BASE | 10'h000, 5'h00, 4'hf);
		chk(mem_wr, {1'b1, 4'he});
		run(`BCIE_OP_BITCLR_BASE | 10'h001, 5'h00, 4'h7);
		chk(mem_wr, {1'b1, 4'h5});
		run(`BCIE_OP_BITCLR_BASE | 10'h002, 5'h00, 4'hf);
		chk(mem_wr, {1'b1, 4'hb});
		run(`BCIE_OP_BITCLR_BASE | 10'h003, 5'h00, 4'hc);
		chk(mem_wr, {1'b1, 4'h4});
	endtask : bitclr_test
	task misc_test;
		run(`BCIE_OP_CARRY_CLR, {4'ha, 1'b1}, 4'h0);
		chk({acc_we, acc_out, skip}, {1'b1, 4'ha, 1'b0, 1'b0});
		// latch set first so the clear has something to clear
		@(posedge clk);
		port_c_set <= 1'b1;
		@(posedge clk);
		port_c_set <= 1'b0;
		#1;
		chk(port_c_latch, 1'b1);
		run(`BCIE_OP_PORTC_CLR, 5'h1f, 4'hf);
		chk({port_c_latch, acc_we, mem_wr.we}, 3'b000);
		// unknown opcode must leave acc_we, mem_wr and skip quiet
		run(10'h3ff, 5'h1f, 4'hf);
		chk({acc_we, mem_wr, skip}, 7'h00);
	endtask : misc_test
	task final_report;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rotate_test();
		bitclr_test();
		misc_test();
		final_report();
	end
	// about 30 cycles of tests; generous margin
	initial begin
		repeat (400) @(posedge clk);
		fails++;
		final_report();
	end
endmodule : test_bit_and_carry_instr_exec
